// File: src/typec_port_control_core.sv
// Notes on behaviour
// R1: three cc comparators, change raises interrupt
// R2: vbus valid comparator readable as status
// R3: drp toggle alternates source and sink terminations
// R4: fixed source or sink role, always monitoring
// R5: power-on reset loads register defaults
// R6: software reset register write restores defaults
// R7: measure vbus only when enabled, store result
// R8: software controls vconn switch, open after reset
// R9: clearing enable opens a closed switch
// R10: overcurrent opens switch and sets fault flag
// R11: received hard reset opens vconn switch
// R12: cable removal opens switch and discharges
// R13: every close-to-open starts rd discharge; reset and soft reset open the switch without one
// R14: at safe zero restore selected termination
// R15: host supplies valid vconn before enabling
// R16: host keeps vconn valid until switch opens
// R17: interrupt pin low while unmasked alert set
// R18: alert flags cleared by writing one
// R19: host clears fault status before fault alert
// R20: vendor interrupts masked by default, two gates
// R21: messages are header plus variable data
// R22: read auto-increments address regardless of ack
// R23: interrupt pin released when nothing unmasked
module typec_port_control_core #(
	parameter int TOGGLE_CYCLES = typec_port_pkg::TOGGLE_HALF_CYCLES,
	parameter int MEAS_WIDTH    = typec_port_pkg::MEAS_WIDTH
) (
	input  wire logic                          clock,
	input  wire logic                          reset,
	input  wire logic                          phyClock,
	input  wire logic                          sclIn,
	input  wire logic                          sdaIn,
	output logic                               sdaOut,
	output logic                               sdaOe,
	output logic                               intOut,
	output logic                               intOe,
	input  wire typec_port_pkg::analog_in_type analogIn,
	input  wire logic [7:0]                    vendorEvent,
	input  wire logic                          hardResetSeen,
	input  wire logic                          sampleValid,
	input  wire logic [MEAS_WIDTH-1:0]         sampleWord,
	output typec_port_pkg::cc_term_type        ccTerm,
	output logic                               vconnSwitch,
	output logic                               vconnDischarge,
	output logic                               measureEnable
);
	localparam int CNT_W = $clog2(TOGGLE_CYCLES + 1);

	initial begin
		if (TOGGLE_CYCLES < 2 || MEAS_WIDTH < 1 || MEAS_WIDTH > 16)
			$error("bad parameters");
	end

	// w1c with set winning over the clear
	function automatic logic [7:0] w1c(input logic [7:0] cur,
		input logic [7:0] set, input logic [7:0] clr, input logic hit);
		return (cur & ~(clr & {8{hit}})) | set;
	endfunction

	// ----------------------------------------------------------------
	// pin and analog synchronisers
	// ----------------------------------------------------------------
	logic [1:0]                    sclSync_q, sdaSync_q;
	logic                          sclPrev_q, sdaPrev_q;
	typec_port_pkg::analog_in_type anaMeta_q, ana_q, anaPrev_q;
	logic [7:0]                    venMeta_q, ven_q;

	// levels from outside the clock domain
	always_ff @(posedge clock) begin
		sclSync_q <= {sclSync_q[0], sclIn};
		sdaSync_q <= {sdaSync_q[0], sdaIn};
		sclPrev_q <= sclSync_q[1];
		sdaPrev_q <= sdaSync_q[1];
		anaMeta_q <= analogIn;
		ana_q     <= anaMeta_q;
		anaPrev_q <= ana_q;
		venMeta_q <= vendorEvent;
		ven_q     <= venMeta_q;
	end

	// ----------------------------------------------------------------
	// link domain: hard reset events and vbus samples
	// ----------------------------------------------------------------
	logic                  linkRstMeta_q, linkRst_q;
	logic                  measMeta_q, measLink_q;
	logic                  ackMeta_q, ackLink_q;
	logic                  hrToggle_q, reqToggle_q;
	logic [MEAS_WIDTH-1:0] sampleHold_q;
	logic                  ackToggle_q;

	always_ff @(posedge phyClock) begin
		linkRstMeta_q <= reset;
		linkRst_q     <= linkRstMeta_q;
		measMeta_q    <= measureEnable;
		measLink_q    <= measMeta_q;
		ackMeta_q     <= ackToggle_q;
		ackLink_q     <= ackMeta_q;
	end

	// hard reset pulse becomes a toggle for the crossing
	always_ff @(posedge phyClock) begin
		if (linkRst_q)
			hrToggle_q <= 1'b0;
		else if (hardResetSeen)
			hrToggle_q <= ~hrToggle_q;
	end

	// hold is stable until the ack returns
	always_ff @(posedge phyClock) begin
		if (linkRst_q) begin
			reqToggle_q  <= 1'b0;
			sampleHold_q <= '0;
		end else if (measLink_q && sampleValid &&
			reqToggle_q == ackLink_q) begin // R7
			sampleHold_q <= sampleWord;
			reqToggle_q  <= ~reqToggle_q;
		end
	end

	// ----------------------------------------------------------------
	// crossing back into the system domain
	// ----------------------------------------------------------------
	logic                  hrMeta_q, hrSync_q, hrPrev_q;
	logic                  reqMeta_q, reqSync_q;
	logic [MEAS_WIDTH-1:0] result_q;
	logic                  softReset_q;
	logic                  regReset;
	logic                  hardResetEvt;

	assign regReset     = reset | softReset_q; // R5 R6
	assign hardResetEvt = hrSync_q ^ hrPrev_q;

	always_ff @(posedge clock) begin
		hrMeta_q  <= hrToggle_q;
		hrSync_q  <= hrMeta_q;
		hrPrev_q  <= hrSync_q;
		reqMeta_q <= reqToggle_q;
		reqSync_q <= reqMeta_q;
	end

	// capture the held sample and answer with the ack toggle
	always_ff @(posedge clock) begin
		if (reset) begin
			ackToggle_q <= 1'b0;
		end else if (reqSync_q != ackToggle_q) begin
			ackToggle_q <= reqSync_q;
		end
	end

	always_ff @(posedge clock) begin
		if (regReset)
			result_q <= '0;
		else if (reqSync_q != ackToggle_q)
			result_q <= sampleHold_q; // R7
	end

	// ----------------------------------------------------------------
	// i2c slave
	// ----------------------------------------------------------------
	typec_port_pkg::i2c_state_type state_q, after_q;
	logic [2:0] bitCnt_q;
	logic       gotByte_q;
	logic [7:0] shift_q, ptr_q, readByte;
	logic       masterAck_q;
	logic       wrStb_q;
	logic [7:0] wrAddr_q, wrData_q;
	logic       sclRise, sclFall, startCond, stopCond;

	assign sclRise   = sclSync_q[1] & ~sclPrev_q;
	assign sclFall   = ~sclSync_q[1] & sclPrev_q;
	assign startCond = sclSync_q[1] & sclPrev_q & sdaPrev_q & ~sdaSync_q[1];
	assign stopCond  = sclSync_q[1] & sclPrev_q & ~sdaPrev_q & sdaSync_q[1];

	// open drain data line: only ever drive low
	always_ff @(posedge clock) begin
		sdaOut <= 1'b0;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state_q     <= typec_port_pkg::ST_IDLE;
			after_q     <= typec_port_pkg::ST_IDLE;
			bitCnt_q    <= 3'h0;
			gotByte_q   <= 1'b0;
			shift_q     <= 8'h00;
			ptr_q       <= 8'h00;
			masterAck_q <= 1'b0;
			sdaOe       <= 1'b0;
			wrStb_q     <= 1'b0;
			wrAddr_q    <= 8'h00;
			wrData_q    <= 8'h00;
		end else begin
			wrStb_q <= 1'b0;
			if (startCond) begin
				state_q   <= typec_port_pkg::ST_ADDR;
				bitCnt_q  <= 3'h0;
				gotByte_q <= 1'b0;
				sdaOe     <= 1'b0;
			end else if (stopCond) begin
				state_q <= typec_port_pkg::ST_IDLE;
				sdaOe   <= 1'b0;
			end else begin
				case (state_q)
				typec_port_pkg::ST_ADDR,
				typec_port_pkg::ST_REG,
				typec_port_pkg::ST_WDATA: begin
					if (sclRise) begin
						shift_q   <= {shift_q[6:0], sdaSync_q[1]};
						bitCnt_q  <= bitCnt_q + 3'h1;
						gotByte_q <= (bitCnt_q == 3'h7);
					end else if (sclFall && gotByte_q) begin
						gotByte_q <= 1'b0;
						state_q   <= typec_port_pkg::ST_ACK;
						sdaOe     <= 1'b1;
						if (state_q == typec_port_pkg::ST_ADDR) begin
							if (shift_q[7:1] != typec_port_pkg::SLAVE_ADDRESS) begin
								state_q <= typec_port_pkg::ST_IDLE;
								sdaOe   <= 1'b0;
							end
							after_q <= shift_q[0] ? typec_port_pkg::ST_RDATA
								: typec_port_pkg::ST_REG;
						end else if (state_q == typec_port_pkg::ST_REG) begin
							ptr_q   <= shift_q;
							after_q <= typec_port_pkg::ST_WDATA;
						end else begin
							wrStb_q  <= 1'b1;
							wrAddr_q <= ptr_q;
							wrData_q <= shift_q;
							ptr_q    <= ptr_q + 8'h01;
							after_q  <= typec_port_pkg::ST_WDATA;
						end
					end
				end
				typec_port_pkg::ST_ACK: begin
					if (sclFall) begin
						state_q  <= after_q;
						bitCnt_q <= 3'h0;
						sdaOe    <= 1'b0;
						if (after_q == typec_port_pkg::ST_RDATA) begin
							shift_q <= readByte;
							sdaOe   <= ~readByte[7];
						end
					end
				end
				typec_port_pkg::ST_RDATA: begin
					if (sclRise) begin
						bitCnt_q  <= bitCnt_q + 3'h1;
						gotByte_q <= (bitCnt_q == 3'h7);
					end else if (sclFall) begin
						if (gotByte_q) begin
							// advance before the master's ack is seen
							gotByte_q <= 1'b0;
							sdaOe     <= 1'b0;
							ptr_q     <= ptr_q + 8'h01; // R22
							state_q   <= typec_port_pkg::ST_RACK;
						end else begin
							shift_q <= {shift_q[6:0], 1'b0};
							sdaOe   <= ~shift_q[6];
						end
					end
				end
				typec_port_pkg::ST_RACK: begin
					if (sclRise) begin
						masterAck_q <= ~sdaSync_q[1];
					end else if (sclFall) begin
						bitCnt_q <= 3'h0;
						if (masterAck_q) begin
							state_q <= typec_port_pkg::ST_RDATA;
							shift_q <= readByte;
							sdaOe   <= ~readByte[7];
						end else begin
							state_q <= typec_port_pkg::ST_IDLE;
						end
					end
				end
				default: begin
					state_q <= typec_port_pkg::ST_IDLE;
				end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [15:0] alert_q, alertMask_q;
	logic [7:0]  portCtl_q, roleCtl_q, powerCtl_q, fault_q;
	logic [7:0]  venInt_q, venMask_q;
	logic [15:0] alertSet, alertView;
	logic [7:0]  faultSet;
	logic        vendorPending, ocRise, cableGone, closeNext;

	// vendor events need their mask and the alert gate
	assign vendorPending = |(venInt_q & venMask_q); // R20
	assign ocRise    = ana_q.overcurrent & ~anaPrev_q.overcurrent;
	assign cableGone = ~ana_q.rdPresent & anaPrev_q.rdPresent;
	assign closeNext = powerCtl_q[typec_port_pkg::POWER_CABLE_EN_BIT]
		& ~ocRise & ~hardResetEvt & ~cableGone;

	always_comb begin
		alertSet = 16'h0000;
		alertSet[typec_port_pkg::ALERT_CC_BIT] =
			(ana_q.ccLevel != anaPrev_q.ccLevel); // R1
		alertSet[typec_port_pkg::ALERT_POWER_BIT] =
			(ana_q.vbusValid != anaPrev_q.vbusValid);
		alertSet[typec_port_pkg::ALERT_HARD_RST_BIT] = hardResetEvt;
		alertSet[typec_port_pkg::ALERT_FAULT_BIT] = ocRise;
		faultSet = 8'h00;
		faultSet[typec_port_pkg::FAULT_OC_BIT] = ocRise; // R10
		alertView = alert_q;
		alertView[typec_port_pkg::ALERT_VENDOR_BIT] = vendorPending;
	end

	// sticky flags, write one clears, a new event wins
	always_ff @(posedge clock) begin
		if (regReset) begin
			alert_q  <= typec_port_pkg::ALERT_RESET;
			fault_q  <= typec_port_pkg::ZERO_BYTE;
			venInt_q <= typec_port_pkg::ZERO_BYTE;
		end else begin
			alert_q[7:0] <= w1c(alert_q[7:0], alertSet[7:0], wrData_q,
				wrStb_q && wrAddr_q == typec_port_pkg::REG_ALERT_LO); // R18
			alert_q[15:8] <= w1c(alert_q[15:8], alertSet[15:8], wrData_q,
				wrStb_q && wrAddr_q == typec_port_pkg::REG_ALERT_HI); // R18
			fault_q <= w1c(fault_q, faultSet, wrData_q,
				wrStb_q && wrAddr_q == typec_port_pkg::REG_FAULT_STAT);
			venInt_q <= w1c(venInt_q, ven_q, wrData_q,
				wrStb_q && wrAddr_q == typec_port_pkg::REG_VENDOR_INT);
		end
	end

	// plain read-write control registers
	always_ff @(posedge clock) begin
		if (regReset) begin
			alertMask_q <= typec_port_pkg::ALERT_MASK_RESET;
			portCtl_q   <= typec_port_pkg::ZERO_BYTE;
			roleCtl_q   <= typec_port_pkg::ROLE_RESET;
			venMask_q   <= typec_port_pkg::ZERO_BYTE; // R20
		end else if (wrStb_q) begin
			case (wrAddr_q)
			typec_port_pkg::REG_MASK_LO:     alertMask_q[7:0]  <= wrData_q;
			typec_port_pkg::REG_MASK_HI:     alertMask_q[15:8] <= wrData_q;
			typec_port_pkg::REG_PORT_CTL:    portCtl_q <= wrData_q;
			typec_port_pkg::REG_ROLE_CTL:    roleCtl_q <= wrData_q;
			typec_port_pkg::REG_VENDOR_MASK: venMask_q <= wrData_q;
			default: begin
			end
			endcase
		end
	end

	// automatic opening beats a same-cycle software write
	always_ff @(posedge clock) begin
		if (regReset) begin
			powerCtl_q <= typec_port_pkg::ZERO_BYTE; // R8
		end else begin
			if (wrStb_q && wrAddr_q == typec_port_pkg::REG_POWER_CTL)
				powerCtl_q <= wrData_q; // R9
			if (ocRise || hardResetEvt || cableGone)
				powerCtl_q[typec_port_pkg::POWER_CABLE_EN_BIT] <= 1'b0; // R10 R11 R12
		end
	end

	// soft reset: one-cycle self-clearing pulse
	always_ff @(posedge clock) begin
		if (reset)
			softReset_q <= 1'b0;
		else
			softReset_q <= wrStb_q && !softReset_q &&
				wrAddr_q == typec_port_pkg::REG_SOFT_RESET &&
				wrData_q[typec_port_pkg::SOFT_RESET_BIT]; // R6
	end

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	logic [15:0] resultWide;
	logic        phaseSink_q;

	assign resultWide = 16'(result_q);

	always_comb begin
		readByte = 8'h00;
		case (ptr_q)
		typec_port_pkg::REG_ALERT_LO:    readByte = alertView[7:0];
		typec_port_pkg::REG_ALERT_HI:    readByte = alertView[15:8];
		typec_port_pkg::REG_MASK_LO:     readByte = alertMask_q[7:0];
		typec_port_pkg::REG_MASK_HI:     readByte = alertMask_q[15:8];
		typec_port_pkg::REG_PORT_CTL:    readByte = portCtl_q;
		typec_port_pkg::REG_ROLE_CTL:    readByte = roleCtl_q;
		typec_port_pkg::REG_POWER_CTL:   readByte = powerCtl_q;
		typec_port_pkg::REG_CC_STAT: begin
			readByte[2:0] = ana_q.ccLevel; // R4
			readByte[typec_port_pkg::CC_PHASE_BIT] = phaseSink_q;
			readByte[typec_port_pkg::CC_LOOKING_BIT] =
				roleCtl_q[typec_port_pkg::ROLE_DRP_BIT];
		end
		typec_port_pkg::REG_POWER_STAT: begin
			readByte[typec_port_pkg::STAT_VBUS_VALID_BIT] = ana_q.vbusValid; // R2
			readByte[typec_port_pkg::STAT_DETECT_EN_BIT] = 1'b1;
		end
		typec_port_pkg::REG_FAULT_STAT:  readByte = fault_q;
		typec_port_pkg::REG_RESULT_LO:   readByte = resultWide[7:0];
		typec_port_pkg::REG_RESULT_HI:   readByte = resultWide[15:8];
		typec_port_pkg::REG_VENDOR_INT:  readByte = venInt_q;
		typec_port_pkg::REG_VENDOR_MASK: readByte = venMask_q;
		default:                         readByte = 8'h00;
		endcase
	end

	// ----------------------------------------------------------------
	// role toggling and terminations
	// ----------------------------------------------------------------
	logic [CNT_W-1:0]            toggleCnt_q;
	logic                        discharging_q;
	typec_port_pkg::cc_term_type termNext;

	// fixed half period; stops when drp mode is left
	always_ff @(posedge clock) begin
		if (regReset || !roleCtl_q[typec_port_pkg::ROLE_DRP_BIT]) begin
			toggleCnt_q <= '0;
			phaseSink_q <= 1'b0;
		end else if (toggleCnt_q == CNT_W'(TOGGLE_CYCLES - 1)) begin
			toggleCnt_q <= '0;
			phaseSink_q <= ~phaseSink_q; // R3
		end else begin
			toggleCnt_q <= toggleCnt_q + CNT_W'(1);
		end
	end

	// discharge starts on any close-to-open except one by reset or soft reset, ends at safe zero
	always_ff @(posedge clock) begin
		if (regReset)
			discharging_q <= 1'b0;
		else if (vconnSwitch && !closeNext)
			discharging_q <= 1'b1; // R13 R12
		else if (ana_q.vconnSafe0v)
			discharging_q <= 1'b0; // R14
	end

	// the discharge pin is the one carrying vconn, not the cc line
	always_comb begin
		if (roleCtl_q[typec_port_pkg::ROLE_DRP_BIT]) begin
			termNext.cc1 = phaseSink_q ? typec_port_pkg::TERM_RD
				: typec_port_pkg::TERM_RP; // R3
			termNext.cc2 = termNext.cc1;
		end else begin
			termNext.cc1 = roleCtl_q[1:0]; // R4
			termNext.cc2 = roleCtl_q[3:2];
		end
		if (discharging_q) begin
			if (portCtl_q[typec_port_pkg::PORT_ORIENT_BIT])
				termNext.cc1 = typec_port_pkg::TERM_RD; // R13
			else
				termNext.cc2 = typec_port_pkg::TERM_RD; // R13
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (regReset) begin
			ccTerm         <= {typec_port_pkg::TERM_RD, typec_port_pkg::TERM_RD};
			vconnSwitch    <= 1'b0; // R8
			vconnDischarge <= 1'b0;
			measureEnable  <= 1'b0;
			intOe          <= 1'b0;
		end else begin
			ccTerm         <= termNext; // R14
			vconnSwitch    <= closeNext; // R9 R10 R11 R12
			vconnDischarge <= discharging_q;
			measureEnable  <= powerCtl_q[typec_port_pkg::POWER_MEAS_EN_BIT]; // R7
			intOe          <= |(alertView & alertMask_q); // R17 R23
		end
	end

	// open drain interrupt: enable does the work
	always_ff @(posedge clock) begin
		intOut <= 1'b0;
	end
endmodule

// File: src/typec_port_pkg.sv
package typec_port_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLOCK_PERIOD_NS    = 8;
	localparam int TOGGLE_HALF_US     = 50;
	localparam int TOGGLE_HALF_CYCLES =
		(TOGGLE_HALF_US * 1000) / CLOCK_PERIOD_NS;
	localparam int MEAS_WIDTH         = 10;

	// ----------------------------------------------------------------
	// i2c slave address and register offsets
	// ----------------------------------------------------------------
	localparam logic [6:0] SLAVE_ADDRESS   = 7'h4e;
	localparam logic [7:0] REG_ALERT_LO    = 8'h10;
	localparam logic [7:0] REG_ALERT_HI    = 8'h11;
	localparam logic [7:0] REG_MASK_LO     = 8'h12;
	localparam logic [7:0] REG_MASK_HI     = 8'h13;
	localparam logic [7:0] REG_PORT_CTL    = 8'h19;
	localparam logic [7:0] REG_ROLE_CTL    = 8'h1a;
	localparam logic [7:0] REG_POWER_CTL   = 8'h1c;
	localparam logic [7:0] REG_CC_STAT     = 8'h1d;
	localparam logic [7:0] REG_POWER_STAT  = 8'h1e;
	localparam logic [7:0] REG_FAULT_STAT  = 8'h1f;
	localparam logic [7:0] REG_RESULT_LO   = 8'h70;
	localparam logic [7:0] REG_RESULT_HI   = 8'h71;
	localparam logic [7:0] REG_VENDOR_INT  = 8'h98;
	localparam logic [7:0] REG_VENDOR_MASK = 8'h99;
	localparam logic [7:0] REG_SOFT_RESET  = 8'ha0;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] ALERT_RESET      = 16'h0002;
	localparam logic [15:0] ALERT_MASK_RESET = 16'h0fff;
	localparam logic [7:0]  ROLE_RESET       = 8'h0a;
	localparam logic [7:0]  ZERO_BYTE        = 8'h00;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int ALERT_CC_BIT        = 0;
	localparam int ALERT_POWER_BIT     = 1;
	localparam int ALERT_HARD_RST_BIT  = 3;
	localparam int ALERT_FAULT_BIT     = 9;
	localparam int ALERT_VENDOR_BIT    = 15;
	localparam int POWER_CABLE_EN_BIT  = 0;
	localparam int POWER_MEAS_EN_BIT   = 6;
	localparam int ROLE_DRP_BIT        = 6;
	localparam int PORT_ORIENT_BIT     = 0;
	localparam int FAULT_OC_BIT        = 1;
	localparam int SOFT_RESET_BIT      = 0;
	localparam int STAT_VBUS_VALID_BIT = 2;
	localparam int STAT_DETECT_EN_BIT  = 3;
	localparam int CC_PHASE_BIT        = 3;
	localparam int CC_LOOKING_BIT      = 5;

	// ----------------------------------------------------------------
	// termination codes
	// ----------------------------------------------------------------
	localparam logic [1:0] TERM_RA   = 2'h0;
	localparam logic [1:0] TERM_RP   = 2'h1;
	localparam logic [1:0] TERM_RD   = 2'h2;
	localparam logic [1:0] TERM_OPEN = 2'h3;

	// ----------------------------------------------------------------
	// carriers and states
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0] ccLevel;
		logic       vbusValid;
		logic       overcurrent;
		logic       rdPresent;
		logic       vconnSafe0v;
	} analog_in_type;

	typedef struct packed {
		logic [1:0] cc2;
		logic [1:0] cc1;
	} cc_term_type;

	typedef enum logic [6:0] {
		ST_IDLE  = 7'h01,
		ST_ADDR  = 7'h02,
		ST_REG   = 7'h04,
		ST_WDATA = 7'h08,
		ST_ACK   = 7'h10,
		ST_RDATA = 7'h20,
		ST_RACK  = 7'h40
	} i2c_state_type;
endpackage

// File: sim/typec_port_control_core_checker.sv
// ------------------------------------------------------------
// vconn, interrupt and i2c pin timing
// ------------------------------------------------------------
module typec_port_control_core_checker (
	input wire logic				clock,
	input wire logic				reset,
	input wire logic				sclIn,
	input wire logic				sdaOut,
	input wire logic				sdaOe,
	input wire logic				intOut,
	input wire logic				intOe,
	input wire typec_port_pkg::analog_in_type	analogIn,
	input wire logic				hardResetSeen,
	input wire typec_port_pkg::cc_term_type	ccTerm,
	input wire logic				vconnSwitch,
	input wire logic				vconnDischarge
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);
	// a closed switch that has just opened
	sequence s_opened;
		$fell(vconnSwitch);
	endsequence
	// discharge running while the line is already safe
	sequence s_drained;
		vconnDischarge && analogIn.vconnSafe0v;
	endsequence
	a_reset_defaults: assert property (
		$fell(reset) |-> ccTerm == 4'ha && !vconnSwitch)
		else $error("reset defaults missing");
	a_cc_change_int: assert property (
		$changed(analogIn.ccLevel) |-> ##[1:10] intOe)
		else $error("cc change raised no interrupt");
	a_oc_opens: assert property (
		analogIn.overcurrent |-> ##[1:10] !vconnSwitch)
		else $error("overcurrent left switch closed");
	a_rd_loss_opens: assert property (
		$fell(analogIn.rdPresent) |-> ##[1:10] !vconnSwitch)
		else $error("cable removal left switch closed");
	a_hard_rst_opens: assert property (
		$rose(hardResetSeen) |-> ##[1:12] !vconnSwitch)
		else $error("hard reset left switch closed");
	a_open_discharge: assert property (
		s_opened |-> ##[0:2] vconnDischarge)
		else $error("opening did not start discharge");
	a_safe_restore: assert property (
		s_drained |-> ##[1:6] !vconnDischarge)
		else $error("discharge kept after safe level");
	a_pins_low_only: assert property (
		!intOut && !sdaOut)
		else $error("open drain pin driven high");
	a_ack_scl_low: assert property (
		$changed(sdaOe) |-> !sclIn)
		else $error("sda moved while scl high");
endmodule

bind typec_port_control_core typec_port_control_core_checker chk (.*);

// File: sim/i2c_host_model.sv
// ------------------------------------------------------------
// port manager as sole i2c master
// ------------------------------------------------------------
module i2c_host_model (
	output logic		scl,
	output logic		sdaRel,
	input wire logic	sdaLine
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl = 1'b1;
		sdaRel = 1'b1;
	end
	// data moves only in scl low, 80 ns each phase
	task automatic bitx(input logic b, output logic r);
		#40 sdaRel = b;
		#40 scl = 1'b1;
		#40 r = sdaLine;
		#40 scl = 1'b0;
	endtask
	// also serves as repeated start
	task automatic start();
		#40 sdaRel = 1'b1;
		#40 scl = 1'b1;
		#40 sdaRel = 1'b0;
		#40 scl = 1'b0;
	endtask
	task automatic stop();
		#40 sdaRel = 1'b0;
		#40 scl = 1'b1;
		#40 sdaRel = 1'b1;
		#40;
	endtask
	// last high releases sda for the slave ack or gives a nack
	task automatic xfer(input logic [7:0] w, input logic last,
		output logic [7:0] r, output logic ack);
		for (int i = 7; i >= 0; i--)
			bitx(w[i], r[i]);
		bitx(last, ack);
	endtask
endmodule

// File: sim/typec_port_control_core_tb_top.sv
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin \
	fail_count++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module typec_port_control_core_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic				clock = 1'b0;
	logic				reset = 1'b1;
	logic				phyClock = 1'b0;
	logic				hardResetSeen = 1'b0;
	logic				sampleValid = 1'b0;
	logic [7:0]			vendorEvent = 8'h00;
	logic [9:0]			sampleWord = 10'h2a5;
	typec_port_pkg::analog_in_type	analogIn = 7'h02;
	typec_port_pkg::cc_term_type	ccTerm;
	logic				sclIn, sdaRel, sdaOut, sdaOe, intOut, intOe;
	logic				vconnSwitch, vconnDischarge, measureEnable;
	logic [7:0]			rv;
	logic				k;
	int				fail_count = 0;
	int				n_tests = 0;
	int				cycles = 0;
	// pull-up on sda: the line is low only if someone pulls it
	wire logic			sdaLine = sdaRel & !sdaOe;
	always #4 clock = ~clock;
	initial begin
		#3;
		forever #16 phyClock = ~phyClock;
	end
	typec_port_control_core #(.TOGGLE_CYCLES(8)) uut (.clock(clock),
		.reset(reset), .phyClock(phyClock), .sclIn(sclIn),
		.sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
		.intOut(intOut), .intOe(intOe), .analogIn(analogIn),
		.vendorEvent(vendorEvent), .hardResetSeen(hardResetSeen),
		.sampleValid(sampleValid), .sampleWord(sampleWord),
		.ccTerm(ccTerm), .vconnSwitch(vconnSwitch),
		.vconnDischarge(vconnDischarge), .measureEnable(measureEnable));
	i2c_host_model host (.scl(sclIn), .sdaRel(sdaRel), .sdaLine(sdaLine));
	// ------------------------------------------------------------
	// access tasks
	// ------------------------------------------------------------
	task automatic settle(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic sel(input logic [7:0] a);
		host.start();
		host.xfer(8'h9c, 1'b1, rv, k);
		host.xfer(a, 1'b1, rv, k);
	endtask
	task automatic cur();
		host.start();
		host.xfer(8'h9d, 1'b1, rv, k);
		host.xfer(8'hff, 1'b1, rv, k);
		host.stop();
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sel(a);
		host.xfer(d, 1'b1, rv, k);
		`CHK("write ack", 1'b0, k)
		host.stop();
		settle(12);
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		sel(a);
		cur();
		`CHK($sformatf("reg %h", a), e, rv)
	endtask
	// bounded wait for a termination pattern
	task automatic tw(input logic [3:0] v);
		for (int i = 0; i < 40 && ccTerm !== v; i++)
			@(negedge clock);
		`CHK("ccTerm", v, ccTerm)
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// hang guard, about three times the expected run
	always @(posedge clock) begin
		cycles++;
		if (cycles == 60000) begin
			fail_count++;
			wrap_up();
		end
	end
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		settle(16);
		reset = 1'b0;
		settle(4);
		`CHK("ccTerm", 4'ha, ccTerm)
		`CHK("vconnSwitch", 1'b0, vconnSwitch)
		`CHK("intOe", 1'b1, intOe)
		rc(8'h10, 8'h02);
		rc(8'h12, 8'hff);
		// pointer moved to 0x13 despite the nack
		cur();
		`CHK("current read", 8'h0f, rv)
		$display("test reset done");
		wr(8'h10, 8'h02);
		`CHK("intOe", 1'b0, intOe)
		analogIn.ccLevel = 3'h1;
		settle(10);
		`CHK("intOe", 1'b1, intOe)
		rc(8'h1d, 8'h01);
		wr(8'h10, 8'h01);
		`CHK("intOe", 1'b0, intOe)
		analogIn.vbusValid = 1'b1;
		settle(10);
		rc(8'h1e, 8'h0c);
		wr(8'h10, 8'h02);
		$display("test alert done");
		rc(8'h70, 8'h00);
		wr(8'h1c, 8'h40);
		`CHK("measureEnable", 1'b1, measureEnable)
		sampleValid = 1'b1;
		settle(40);
		rc(8'h70, 8'ha5);
		rc(8'h71, 8'h02);
		$display("test measure done");
		wr(8'h1a, 8'h05);
		`CHK("ccTerm", 4'h5, ccTerm)
		wr(8'h1c, 8'h01);
		`CHK("vconnSwitch", 1'b1, vconnSwitch)
		wr(8'h1c, 8'h00);
		`CHK("vconnSwitch", 1'b0, vconnSwitch)
		`CHK("vconnDischarge", 1'b1, vconnDischarge)
		`CHK("ccTerm", 4'h9, ccTerm)
		analogIn.vconnSafe0v = 1'b1;
		settle(10);
		`CHK("vconnDischarge", 1'b0, vconnDischarge)
		`CHK("ccTerm", 4'h5, ccTerm)
		analogIn.vconnSafe0v = 1'b0;
		wr(8'h1c, 8'h01);
		analogIn.overcurrent = 1'b1;
		settle(10);
		`CHK("vconnSwitch", 1'b0, vconnSwitch)
		rc(8'h1f, 8'h02);
		rc(8'h11, 8'h02);
		analogIn.overcurrent = 1'b0;
		wr(8'h1f, 8'h02);
		wr(8'h11, 8'h02);
		rc(8'h11, 8'h00);
		wr(8'h1c, 8'h01);
		@(negedge phyClock) hardResetSeen = 1'b1;
		@(negedge phyClock) hardResetSeen = 1'b0;
		settle(10);
		`CHK("vconnSwitch", 1'b0, vconnSwitch)
		rc(8'h10, 8'h08);
		wr(8'h10, 8'h08);
		wr(8'h1c, 8'h01);
		analogIn.rdPresent = 1'b0;
		settle(10);
		`CHK("vconnSwitch", 1'b0, vconnSwitch)
		`CHK("vconnDischarge", 1'b1, vconnDischarge)
		analogIn.vconnSafe0v = 1'b1;
		$display("test vconn done");
		vendorEvent = 8'h01;
		settle(6);
		vendorEvent = 8'h00;
		rc(8'h98, 8'h01);
		`CHK("intOe", 1'b0, intOe)
		wr(8'h99, 8'h01);
		`CHK("intOe", 1'b0, intOe)
		wr(8'h13, 8'h8f);
		`CHK("intOe", 1'b1, intOe)
		wr(8'h98, 8'h01);
		`CHK("intOe", 1'b0, intOe)
		$display("test vendor done");
		wr(8'h1a, 8'h40);
		tw(4'h5);
		tw(4'ha);
		wr(8'ha0, 8'h01);
		rc(8'h1a, 8'h0a);
		rc(8'h13, 8'h0f);
		`CHK("ccTerm", 4'ha, ccTerm)
		$display("test toggle done");
		wrap_up();
	end
endmodule
